// ### rtl/ddrini_pkg.sv
// Package for the DDR memory initialisation sequencer block
package ddrini_pkg;
    // Command bus decode (device side of the command pins)
    typedef enum logic [2:0] {
        DDRINI_CMD_NOP,
        DDRINI_CMD_MODE_LOAD,
        DDRINI_CMD_REFRESH,
        DDRINI_CMD_READ,
        DDRINI_CMD_WRITE
    } ddrini_cmd_type;

    typedef struct packed {
        ddrini_cmd_type cmd;
        logic [2:0]     bank;
        logic [19:0]    addr;
    } ddrini_req_type;

    // Wishbone register byte offsets
    localparam logic [7:0] DDRINI_REG_STATUS  = 8'h00;
    localparam logic [7:0] DDRINI_REG_MODE    = 8'h04;
    localparam logic [7:0] DDRINI_REG_REFMASK = 8'h08;
    localparam logic [7:0] DDRINI_REG_NOPCNT  = 8'h0C;
    localparam logic [7:0] DDRINI_REG_CTRL    = 8'h10;

    // Mode word field positions
    localparam int DDRINI_MODE_BL_LSB   = 3;
    localparam int DDRINI_MODE_DLL_BIT  = 7;
    localparam int DDRINI_MUX_SEL_BIT   = 5;
    localparam int DDRINI_PH2_BIT8      = 8;

    localparam logic [19:0] DDRINI_MODE_RESET  = 20'h00000;
    localparam logic [2:0]  DDRINI_BL_EIGHT    = 3'h2;
    localparam int          DDRINI_MIN_LOADS   = 3;
    localparam int          DDRINI_BANKS       = 8;
    localparam int          DDRINI_PAD_NOPS    = 1024;

    // Mode-load settle time, in ns, and its cycle count at 8 ns
    localparam int DDRINI_CLK_PS        = 8000;
    localparam int DDRINI_SETTLE_NS     = 48;
    localparam int DDRINI_SETTLE_CYC    =
        (DDRINI_SETTLE_NS * 1000 + DDRINI_CLK_PS - 1) / DDRINI_CLK_PS;
    localparam int DDRINI_BASE_RL       = 4;
endpackage

// ### rtl/ddrini_core.sv
// Device-side initialisation, mode register and latency tracking
//
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
module ddrini_core (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire ddrini_pkg::ddrini_req_type req,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    output logic                         init_done,
    output logic                         mux_mode,
    output logic                         dll_on,
    output logic      [3:0]              read_latency,
    output logic      [3:0]              write_latency,
    output logic                         bl_error
);
    typedef enum logic [1:0] {
        DDRINI_ST_LOADS,
        DDRINI_ST_SETTLE,
        DDRINI_ST_REFRESH,
        DDRINI_ST_READY
    } ddrini_state_type;

    ddrini_state_type  state_q, state_d;
    logic [1:0]        loads_q, loads_d;
    logic [7:0]        settle_q, settle_d;
    logic [10:0]       nops_q, nops_d;
    logic [7:0]        banks_q, banks_d;
    logic [19:0]       mode_q, mode_d;
    logic              mux_q, mux_d;
    logic              ph2_q, ph2_d;
    logic              blerr_q, blerr_d;
    logic              ack_q, ack_d;
    logic [31:0]       rdat_q, rdat_d;
    logic [3:0]        base_rl_q, base_rl_d;
    logic              restart_q, restart_d;
    logic              wb_req;
    logic [2:0]        bl_field;
    logic              bl_set;

    assign wb_req   = wb_cyc_i && wb_stb_i && !ack_q;
    assign bl_field = req.addr[ddrini_pkg::DDRINI_MODE_BL_LSB +: 3];
    // Hardware set beats a software clear in the same cycle
    assign bl_set   = req.cmd == ddrini_pkg::DDRINI_CMD_MODE_LOAD && !ph2_q
                      && mux_q && bl_field == ddrini_pkg::DDRINI_BL_EIGHT;

    always_comb begin
        state_d   = state_q;
        loads_d   = loads_q;
        settle_d  = settle_q;
        nops_d    = nops_q;
        banks_d   = banks_q;
        mode_d    = mode_q;
        mux_d     = mux_q;
        ph2_d     = 1'b0;
        blerr_d   = blerr_q;
        base_rl_d = base_rl_q;
        restart_d = 1'b0;
        if (settle_q != 8'h00) begin
            settle_d = settle_q - 8'h01;
        end
        if (req.cmd == ddrini_pkg::DDRINI_CMD_MODE_LOAD) begin
            if (loads_q != 2'h3) begin
                loads_d = loads_q + 2'h1;
            end
        end else if (state_q == DDRINI_ST_LOADS) begin
            loads_d = 2'h0;
        end
        if (ph2_q) begin
            mode_d[ddrini_pkg::DDRINI_PH2_BIT8 - 1:0] = req.addr[7:0];
        end else if (req.cmd == ddrini_pkg::DDRINI_CMD_MODE_LOAD) begin
            settle_d = 8'(ddrini_pkg::DDRINI_SETTLE_CYC);
            if (req.addr[ddrini_pkg::DDRINI_MUX_SEL_BIT] && !mux_q) begin
                mux_d = 1'b1;
            end else if (mux_q) begin
                ph2_d  = 1'b1;
                mode_d = {req.addr[19:8], mode_q[7:0]};
            end else begin
                mode_d = req.addr;
            end
            // flag long bursts in mux mode
            if (bl_set) begin
                blerr_d = 1'b1;
            end
        end
        case (state_q)
            DDRINI_ST_LOADS: begin
                if (req.cmd != ddrini_pkg::DDRINI_CMD_MODE_LOAD
                        && 32'(loads_q) >= ddrini_pkg::DDRINI_MIN_LOADS) begin
                    state_d = DDRINI_ST_SETTLE;
                end
            end
            DDRINI_ST_SETTLE: begin
                if (settle_q == 8'h00) begin
                    state_d = DDRINI_ST_REFRESH;
                    nops_d  = 11'h000;
                    banks_d = 8'h00;
                end
            end
            DDRINI_ST_REFRESH: begin
                if (req.cmd == ddrini_pkg::DDRINI_CMD_REFRESH) begin
                    banks_d = banks_q | (8'h01 << req.bank);
                end else if (req.cmd == ddrini_pkg::DDRINI_CMD_NOP
                        && nops_q != 11'(ddrini_pkg::DDRINI_PAD_NOPS)) begin
                    nops_d = nops_q + 11'h001;
                end
                if (banks_q == 8'hFF
                        && nops_q == 11'(ddrini_pkg::DDRINI_PAD_NOPS)) begin
                    state_d = DDRINI_ST_READY;
                end
            end
            DDRINI_ST_READY: begin
                if (restart_q) begin
                    state_d = DDRINI_ST_LOADS;
                    loads_d = 2'h0;
                end
            end
            default: state_d = DDRINI_ST_LOADS;
        endcase
        ack_d  = wb_req;
        rdat_d = rdat_q;
        if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                ddrini_pkg::DDRINI_REG_STATUS:
                    rdat_d = {26'h0, blerr_q, dll_on, mux_q,
                              state_q == DDRINI_ST_READY, state_q};
                ddrini_pkg::DDRINI_REG_MODE:
                    rdat_d = {12'h0, mode_q};
                ddrini_pkg::DDRINI_REG_REFMASK:
                    rdat_d = {24'h0, banks_q};
                ddrini_pkg::DDRINI_REG_NOPCNT:
                    rdat_d = {21'h0, nops_q};
                ddrini_pkg::DDRINI_REG_CTRL:
                    rdat_d = {28'h0, base_rl_q};
                default:
                    rdat_d = 32'h0;
            endcase
        end
        if (wb_req && wb_we_i && wb_sel_i[0]
                && wb_adr_i == ddrini_pkg::DDRINI_REG_CTRL) begin
            base_rl_d = wb_dat_i[3:0];
            restart_d = wb_dat_i[4];
            if (wb_dat_i[5] && !bl_set) begin
                blerr_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q   <= DDRINI_ST_LOADS;
            loads_q   <= 2'h0;
            settle_q  <= 8'h00;
            nops_q    <= 11'h000;
            banks_q   <= 8'h00;
            mode_q    <= ddrini_pkg::DDRINI_MODE_RESET;
            mux_q     <= 1'b0;
            ph2_q     <= 1'b0;
            blerr_q   <= 1'b0;
            ack_q     <= 1'b0;
            rdat_q    <= 32'h0;
            base_rl_q <= 4'(ddrini_pkg::DDRINI_BASE_RL);
            restart_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            loads_q   <= loads_d;
            settle_q  <= settle_d;
            nops_q    <= nops_d;
            banks_q   <= banks_d;
            mode_q    <= mode_d;
            mux_q     <= mux_d;
            ph2_q     <= ph2_d;
            blerr_q   <= blerr_d;
            ack_q     <= ack_d;
            rdat_q    <= rdat_d;
            base_rl_q <= base_rl_d;
            restart_q <= restart_d;
        end
    end

    assign wb_ack_o      = ack_q;
    assign wb_dat_o      = rdat_q;
    assign init_done     = (state_q == DDRINI_ST_READY);
    assign mux_mode      = mux_q;
    assign dll_on        = !mode_q[ddrini_pkg::DDRINI_MODE_DLL_BIT];
    assign read_latency  = base_rl_q + {3'h0, mux_q};
    assign write_latency = read_latency + 4'h1;
    assign bl_error      = blerr_q;
endmodule

// ### bench/ddrini_checker_assertions.sv
// Port assertions for the init sequencer
`timescale 1ns/1ps
module ddrini_checker (
    input wire logic                       clk,
    input wire logic                       reset,
    input wire ddrini_pkg::ddrini_req_type req,
    input wire logic                       wb_cyc_i,
    input wire logic                       wb_stb_i,
    input wire logic                       wb_ack_o,
    input wire logic                       init_done,
    input wire logic                       mux_mode,
    input wire logic                       dll_on,
    input wire logic [3:0]                 read_latency,
    input wire logic [3:0]                 write_latency,
    input wire logic                       bl_error
);
    logic ld;
    assign ld = req.cmd == ddrini_pkg::DDRINI_CMD_MODE_LOAD;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence taken; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence mux_entry; ld && req.addr[5] && !mux_mode; endsequence
    sequence three_loads; ld [*3]; endsequence
    AST_WB_ANSWER: assert property (taken |=> wb_ack_o)
        else $error("ack missing");
    AST_WB_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    AST_WB_IDLE: assert property (!wb_stb_i |=> !wb_ack_o)
        else $error("ack without request");
    AST_WL_RL:
        assert property (write_latency == read_latency + 4'h1)
        else $error("write latency off");
    AST_MUX_ENTER: assert property (mux_entry |=> mux_mode)
        else $error("mux mode not entered");
    AST_MUX_LAT:
        assert property ($rose(mux_mode) |->
            read_latency == $past(read_latency) + 4'h1)
        else $error("mux latency off");
    AST_DLL_OFF:
        assert property (ld && !mux_mode && req.addr[7] && !req.addr[5]
            |=> !dll_on) else $error("dll still on");
    AST_INIT_LOAD: assert property (three_loads |=> !init_done)
        else $error("init done during loads");
    AST_BL_FLAG:
        assert property (ld && mux_mode && req.addr[5:3] == 3'h2
            |=> bl_error) else $error("long burst not flagged");
endmodule
bind ddrini_core ddrini_checker u_chk (.*);

// ### bench/ddrini_ctl_model.sv
// Controller model driving the power-up command stream
`timescale 1ns/1ps
module ddrini_ctl_model #(
    parameter int HOLD_CYC = 25000
) (
    input  wire logic                       clk,
    input  wire logic                       go,
    input  wire ddrini_pkg::ddrini_req_type host_req,
    output ddrini_pkg::ddrini_req_type      req,
    output logic                            busy
);
    ddrini_pkg::ddrini_req_type seq_q;
    assign req = busy ? seq_q : host_req;
    task step(input ddrini_pkg::ddrini_cmd_type c, input int b);
        seq_q <= '{c, 3'(b), 20'h00000};
        @(posedge clk);
    endtask
    task nop(input int n);
        repeat (n) step(ddrini_pkg::DDRINI_CMD_NOP, 0);
    endtask
    initial begin
        busy = 1'b0;
        seq_q = '0;
        forever begin
            @(posedge clk);
            if (go) begin
                busy <= 1'b1;
                nop(HOLD_CYC);
                repeat (3) step(ddrini_pkg::DDRINI_CMD_MODE_LOAD, 0);
                nop(8);
                for (int b = 7; b >= 0; b--) begin
                    step(ddrini_pkg::DDRINI_CMD_REFRESH, b);
                end
                nop(1024);
                busy <= 1'b0;
            end
        end
    end
endmodule

// ### bench/test_ddr_memory_init_sequence.sv
// Self-checking bench for the init sequencer
`timescale 1ns/1ps
module test_ddr_memory_init_sequence;
    typedef struct { logic [7:0] a; logic [31:0] e; } ddrini_row_type;
    logic                       clk = 1'b0, reset = 1'b1, go = 1'b0;
    logic                       cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic                       init_done, mux_mode, dll_on, bl_err;
    logic [7:0]                 adr = 8'h00;
    logic [31:0]                wdat = 32'h0, rdat, dat_o;
    logic [3:0]                 rl, wl;
    ddrini_pkg::ddrini_req_type host_req = '0, req;
    int                         miscompares = 0, cmp_count = 0;
    ddrini_row_type rows [6] = '{'{8'h00, 32'h10}, '{8'h04, 32'h0},
        '{8'h08, 32'h0}, '{8'h0C, 32'h0}, '{8'h10, 32'h4}, '{8'h20, 32'h0}};
    always #4 clk = ~clk;
    ddrini_ctl_model u_ctl (.clk(clk), .go(go), .host_req(host_req),
        .req(req), .busy());
    ddrini_core dut (.clk(clk), .reset(reset), .req(req), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .init_done(init_done), .mux_mode(mux_mode), .dll_on(dll_on),
        .read_latency(rl), .write_latency(wl), .bl_error(bl_err));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // Only the watchdog ends a wait for the answer
        do @(posedge clk); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // Command holds until the next call replaces it
    task cmd(input ddrini_pkg::ddrini_cmd_type c, input logic [19:0] a);
        @(posedge clk);
        host_req <= '{c, 3'h0, a};
    endtask
    task traffic(input ddrini_pkg::ddrini_cmd_type c, input logic [2:0] b);
        @(posedge clk);
        host_req <= '{c, b, 20'h00000};
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #(8 * 40000);
        miscompares++;
        close_out;
    end
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk(32'({bl_err, rl, wl}), 32'h045);
        // Unmapped write must leave every row intact
        wb(1'b1, 8'h20, 32'hFFFFFFFF);
        foreach (rows[i]) begin
            wb(1'b0, rows[i].a, 32'h0);
            chk(rdat, rows[i].e);
        end
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (int n = 0; n < 27000 && init_done !== 1'b1; n++) @(posedge clk);
        chk(32'(init_done), 32'h1);
        wb(1'b0, 8'h08, 32'h0);
        chk(rdat, 32'hFF);
        cmd(ddrini_pkg::DDRINI_CMD_MODE_LOAD, 20'h00080);
        cmd(ddrini_pkg::DDRINI_CMD_NOP, 20'h00000);
        @(posedge clk);
        chk(32'(dll_on), 32'h0);
        cmd(ddrini_pkg::DDRINI_CMD_MODE_LOAD, 20'h00000);
        cmd(ddrini_pkg::DDRINI_CMD_NOP, 20'h00000);
        @(posedge clk);
        chk(32'(dll_on), 32'h1);
        cmd(ddrini_pkg::DDRINI_CMD_MODE_LOAD, 20'h00020);
        cmd(ddrini_pkg::DDRINI_CMD_NOP, 20'h00000);
        @(posedge clk);
        chk(32'({mux_mode, rl, wl}), 32'h156);
        repeat (8) @(posedge clk);
        cmd(ddrini_pkg::DDRINI_CMD_MODE_LOAD, 20'h00000);
        cmd(ddrini_pkg::DDRINI_CMD_NOP, 20'h00120);
        cmd(ddrini_pkg::DDRINI_CMD_NOP, 20'h00000);
        wb(1'b0, 8'h04, 32'h0);
        chk(rdat, 32'h20);
        // Each bank once, so no row cycle wait is owed
        traffic(ddrini_pkg::DDRINI_CMD_REFRESH, 3'h0);
        traffic(ddrini_pkg::DDRINI_CMD_WRITE, 3'h1);
        traffic(ddrini_pkg::DDRINI_CMD_NOP, 3'h0);
        traffic(ddrini_pkg::DDRINI_CMD_NOP, 3'h0);
        traffic(ddrini_pkg::DDRINI_CMD_READ, 3'h2);
        traffic(ddrini_pkg::DDRINI_CMD_WRITE, 3'h3);
        traffic(ddrini_pkg::DDRINI_CMD_READ, 3'h4);
        traffic(ddrini_pkg::DDRINI_CMD_NOP, 3'h0);
        @(posedge clk);
        chk(32'({init_done, mux_mode, bl_err}), 32'h6);
        cmd(ddrini_pkg::DDRINI_CMD_MODE_LOAD, 20'h00010);
        cmd(ddrini_pkg::DDRINI_CMD_NOP, 20'h00020);
        @(posedge clk);
        chk(32'(bl_err), 32'h1);
        wb(1'b1, 8'h10, 32'h26);
        chk(32'({bl_err, rl, wl}), 32'h078);
        wb(1'b1, 8'h10, 32'h16);
        @(posedge clk);
        chk(32'(init_done), 32'h0);
        close_out;
    end
endmodule
